//--- pkg/abs_pkg.sv
// Constants shared by the converter boundary-scan segment.
`default_nettype none

package abs_pkg;

    // ========================================================================
    // Scan chain layout, cell 0 sits next to the serial output.
    localparam int unsigned SEG_LEN   = 28;
    localparam int unsigned CELL_CMP  = 0;
    localparam int unsigned CELL_ACLK = 1;
    localparam int unsigned CELL_ACT  = 2;
    localparam int unsigned CELL_BGN  = 3;
    localparam int unsigned CELL_CPW  = 4;
    localparam int unsigned CELL_DPW  = 5;
    localparam int unsigned CELL_DAC  = 6;
    localparam int unsigned DAC_W     = 10;
    localparam int unsigned CELL_BYP  = 16;
    localparam int unsigned CELL_GND  = 17;
    localparam int unsigned CELL_HLD  = 18;
    localparam int unsigned CELL_REF  = 19;
    localparam int unsigned CELL_MUX  = 20;
    localparam int unsigned MUX_W     = 8;

    // ========================================================================
    // Idle line values: trial code 0x200, hold, bypass and channel bit 0 set.
    localparam logic [SEG_LEN-1:0] IDLE_LINES = 28'h0158000;
    localparam logic [9:0]         DAC_IDLE   = 10'h200;
    localparam logic [7:0]         MUX_IDLE   = 8'h01;

    // ========================================================================
    // Register map on the APB side.
    localparam int unsigned  ADDR_W     = 12;
    localparam logic [11:0]  OFS_CTRL   = 12'h000;
    localparam logic [11:0]  OFS_LINES  = 12'h004;
    localparam logic [11:0]  OFS_CHAIN  = 12'h008;
    localparam logic         CTRL_RESET = 1'b1;

endpackage

`default_nettype wire

//--- src/abs_segment.sv
// Boundary-scan segment driving and observing the converter control lines.
//
// Notes on behaviour
// - One scan cell per converter control input and observe output.
// - Ten trial code cells, bit 9 down to 0; idle code has bit 9 only.
// - Hold cell low makes converter track, high holds; idles high.
// - Bypass cell routes channels zero to three around amplifier; idles high.
// - Separate converter and amplifier power cells, both idle low.
// - Ground, band-gap negative input and band-gap reference cells idle low.
// - Amplifier path enable and amplifier clock cells idle low.
// - Idle inputs read back idle values; comparator zero, channel bit 0 only.
`default_nettype none

module abs_segment (
    // Clock, reset and freeze.
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       ce,
    // APB slave.
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [abs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Test access port states and tdi from the TCK domain; tdo is registered on pclk.
    input  wire logic                       tck,
    input  wire logic                       tdi,
    input  wire logic                       capture_dr,
    input  wire logic                       shift_dr,
    input  wire logic                       update_dr,
    output logic                            tdo,
    // Converter observe line.
    input  wire logic                       comp,
    // Converter control lines.
    output logic                            aclk,
    output logic                            amp_to_cmp_path_en,
    output logic                            bandgap_neg_input_en,
    output logic                            converter_power_on,
    output logic                            diffamp_power_on,
    output logic      [9:0]                 dac_code,
    output logic                            amp_bypass_route,
    output logic                            neg_input_ground,
    output logic                            sample_hold,
    output logic                            bandgap_as_dac_ref,
    output logic      [7:0]                 channel_select
);

    localparam int unsigned N = abs_pkg::SEG_LEN;

    // ========================================================================
    // Synchronisers. TCK is slow against pclk, so its edges are found here
    // and all TAP qualifiers pass the same two stages to stay aligned.
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic       tck_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            tck_d <= 1'b0;
        end else if (ce) begin
            sync1 <= {comp, update_dr, shift_dr, capture_dr, tdi, tck};
            sync2 <= sync1;
            tck_d <= sync2[0];
        end
    end

    logic tck_s;
    logic tdi_s;
    logic cap_s;
    logic shf_s;
    logic upd_s;
    logic comp_s;
    assign {comp_s, upd_s, shf_s, cap_s, tdi_s, tck_s} = sync2;

    logic en_q;
    logic tck_rise;
    logic tck_fall;
    logic cap_fire;
    logic shift_fire;
    logic upd_fire;
    assign tck_rise   = tck_s & ~tck_d;
    assign tck_fall   = ~tck_s & tck_d;
    assign cap_fire   = en_q & tck_rise & cap_s;
    assign shift_fire = en_q & tck_rise & shf_s & ~cap_s;
    assign upd_fire   = en_q & tck_fall & upd_s;

    // ========================================================================
    // Scan cells, update latches and APB registers.
    logic [N-1:0] chain;
    logic [N-1:1] line_q;
    logic         tdo_q;
    logic [N-1:0] next_chain;
    logic [N-1:1] next_line;
    logic         next_tdo;
    logic         next_en;
    logic [31:0]  next_prdata;
    logic         next_pready;
    logic         next_pslverr;

    always_comb begin
        next_chain   = chain;
        next_line    = line_q;
        next_tdo     = tdo_q;
        next_en      = en_q;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (cap_fire) begin
            // Control cells capture what they drive so a scan reads the lines back.
            next_chain[abs_pkg::CELL_CMP] = comp_s;
            next_chain[N-1:1]             = line_q;
        end else if (shift_fire) begin
            next_chain = {tdi_s, chain[N-1:1]};
        end
        if (upd_fire) begin
            next_line = chain[N-1:1];
        end
        // Serial output changes on the falling edge, as the tester samples late in the high phase.
        if (tck_fall) begin
            next_tdo = chain[0];
        end
        if (psel && !penable) begin
            next_pready = 1'b1;
            unique case (paddr)
                abs_pkg::OFS_CTRL:  next_prdata = {31'h00000000, en_q};
                abs_pkg::OFS_LINES: next_prdata = {5'h00, line_q};
                abs_pkg::OFS_CHAIN: next_prdata = {4'h0, chain};
                default: begin
                    next_prdata  = 32'h00000000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pready && pwrite && paddr == abs_pkg::OFS_CTRL) begin
            next_en = pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain   <= abs_pkg::IDLE_LINES;
            line_q  <= abs_pkg::IDLE_LINES[N-1:1];
            tdo_q   <= 1'b0;
            en_q    <= abs_pkg::CTRL_RESET;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            chain   <= next_chain;
            line_q  <= next_line;
            tdo_q   <= next_tdo;
            en_q    <= next_en;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ========================================================================
    // Line outputs come straight from the update latches.
    assign tdo                  = tdo_q;
    assign aclk                 = line_q[abs_pkg::CELL_ACLK];
    assign amp_to_cmp_path_en   = line_q[abs_pkg::CELL_ACT];
    assign bandgap_neg_input_en = line_q[abs_pkg::CELL_BGN];
    assign converter_power_on   = line_q[abs_pkg::CELL_CPW];
    assign diffamp_power_on     = line_q[abs_pkg::CELL_DPW];
    assign dac_code             = line_q[abs_pkg::CELL_DAC +: abs_pkg::DAC_W];
    assign amp_bypass_route     = line_q[abs_pkg::CELL_BYP];
    assign neg_input_ground     = line_q[abs_pkg::CELL_GND];
    assign sample_hold          = line_q[abs_pkg::CELL_HLD];
    assign bandgap_as_dac_ref   = line_q[abs_pkg::CELL_REF];
    assign channel_select       = line_q[abs_pkg::CELL_MUX +: abs_pkg::MUX_W];

    // ========================================================================
    // Checks. A flag remembers whether any update has happened since reset.
    logic upd_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_seen <= 1'b0;
        end else if (ce && upd_fire) begin
            upd_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    idle_lines_a: assert property (!upd_seen |-> dac_code == abs_pkg::DAC_IDLE && sample_hold
        && amp_bypass_route && channel_select == abs_pkg::MUX_IDLE && !converter_power_on)
        else $error("lines left idle values before any update");
    shift_move_a: assert property (ce && shift_fire |=> chain[N-1] == $past(tdi_s)
        && chain[N-2:0] == $past(chain[N-1:1]))
        else $error("scan chain did not shift by one cell");
    dac_update_a: assert property (ce && upd_fire |=> dac_code == $past(chain[15:6]))
        else $error("trial code not loaded on update");
    hold_track_a: assert property (ce && upd_fire && !chain[abs_pkg::CELL_HLD] |=> !sample_hold [*2])
        else $error("hold line did not go to track");
    bypass_upd_a: assert property (ce && upd_fire |=> amp_bypass_route == $past(chain[16]))
        else $error("bypass line not loaded on update");
    power_upd_a: assert property (ce && upd_fire |=> {converter_power_on, diffamp_power_on}
        == $past({chain[4], chain[5]}))
        else $error("power lines not loaded on update");
    negsel_upd_a: assert property (ce && upd_fire |=> {neg_input_ground, bandgap_neg_input_en,
        bandgap_as_dac_ref} == $past({chain[17], chain[3], chain[19]}))
        else $error("reference selects not loaded on update");
    amp_upd_a: assert property (ce && upd_fire |=> {aclk, amp_to_cmp_path_en}
        == $past({chain[1], chain[2]}))
        else $error("amplifier lines not loaded on update");
    lines_stable_a: assert property (!(ce && upd_fire) |=> $stable(line_q))
        else $error("lines changed outside update");
    comp_capture_a: assert property (ce && cap_fire |=> chain[0] == $past(comp_s)
        && chain[N-1:1] == $past(line_q))
        else $error("capture did not load comparator and lines");

    capture_c: cover property (ce && cap_fire ##[1:400] ce && shift_fire);
    update_c:  cover property (ce && upd_fire ##1 !sample_hold);
    apb_c:     cover property (psel && penable && pready && pwrite);
    error_c:   cover property (pready && pslverr);

endmodule

`default_nettype wire

//--- verification/abs_tester.sv
// Tester model that frames scan traffic on the link clock.
`default_nettype none
module abs_tester (
    // Pacing clock and serial data back.
    input  wire logic pclk,
    input  wire logic tdo,
    // Link clock, serial data and TAP state levels.
    output logic      tck,
    output logic      tdi,
    output logic      capture_dr,
    output logic      shift_dr,
    output logic      update_dr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {tck, tdi, capture_dr, shift_dr, update_dr} = 5'h00;
    // A link period is 8 pclk; tdo is read late in the high phase.
    task automatic pulse(output logic seen);
        repeat (2) @(posedge pclk);
        tck <= 1'b1;
        repeat (4) @(posedge pclk);
        seen = tdo;
        tck <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic scan(input logic [27:0] vin, output logic [27:0] vout);
        logic s;
        capture_dr <= 1'b1;
        pulse(s);
        {capture_dr, shift_dr} <= 2'b01;
        for (int i = 0; i < 28; i++) begin
            tdi <= vin[i];
            pulse(vout[i]);
        end
        // A released data line shows the inverse of its last bit.
        {shift_dr, update_dr, tdi} <= {2'b01, ~vin[27]};
        pulse(s);
        update_dr <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the converter scan segment.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, comp, err, sample_hold;
    logic        tck, tdi, capture_dr, shift_dr, update_dr, tdo, aclk, amp_to_cmp_path_en, bandgap_neg_input_en;
    logic        converter_power_on, diffamp_power_on, amp_bypass_route, neg_input_ground, bandgap_as_dac_ref;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  dac_code;
    logic [7:0]  channel_select;
    logic [27:0] seen_lines, vout, prev = 28'h0158000;
    int          miscompares = 0, total_checks = 0;
    // Lines for cells 27..0 beside the comparator level.
    logic [28:0] rows [6] = '{{28'h0858010, 1'b1}, {28'h0818010, 1'b0}, {28'h08548D0, 1'b1},
                              {28'h80EFFFE, 1'b0}, {28'h0158000, 1'b0}, {28'h0158000, 1'b0}};
    assign seen_lines = {channel_select, bandgap_as_dac_ref, sample_hold, neg_input_ground, amp_bypass_route, dac_code,
                         diffamp_power_on, converter_power_on, bandgap_neg_input_en, amp_to_cmp_path_en, aclk, 1'b0};
    abs_segment dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                     .tck, .tdi, .capture_dr, .shift_dr, .update_dr, .tdo, .comp, .aclk, .amp_to_cmp_path_en,
                     .bandgap_neg_input_en, .converter_power_on, .diffamp_power_on, .dac_code, .amp_bypass_route,
                     .neg_input_ground, .sample_hold, .bandgap_as_dac_ref, .channel_select);
    abs_tester tester (.pclk, .tdo, .tck, .tdi, .capture_dr, .shift_dr, .update_dr);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("%0d checks, %0d mismatches", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        // Letting an edge pass keeps psel from being assigned twice in one step.
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        check("pready", 32'h1, 32'(pready));
        if (n == 20) give_verdict();
    endtask
    // Lines must not move while a vector shifts through.
    always @(posedge pclk) if (shift_dr === 1'b1) check("shift", 32'(prev), 32'(seen_lines));
    initial begin
        {presetn, ce, psel, penable, pwrite, comp, paddr, pwdata} = {6'b010000, 12'h000, 32'h0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl", 32'h1, rd);
        foreach (rows[k]) begin
            comp <= rows[k][0];
            tester.scan(rows[k][28:1], vout);
            check("capture", 32'({prev[27:1], rows[k][0]}), 32'(vout));
            check("lines", 32'(rows[k][28:1]), 32'(seen_lines));
            apb(1'b0, 12'h004, 32'h0);
            check("lines reg", 32'(rows[k][28:2]), rd);
            prev = rows[k][28:1];
            $display("row %0d done", k);
        end
        // Unmapped offset errs; read-only offsets ignore writes.
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        apb(1'b0, 12'h008, 32'h0);
        check("chain reg", 32'h00158000, rd);
        apb(1'b1, 12'h000, 32'h0);
        tester.scan(28'h80EFFFE, vout);
        check("disabled", 32'h0158000, 32'(seen_lines));
        apb(1'b1, 12'h000, 32'h1);
        tester.scan(28'h80EFFFE, vout);
        check("enabled", 32'h80EFFFE, 32'(seen_lines));
        prev = 28'h80EFFFE;
        // A low clock enable freezes the synchronisers, so a whole frame is lost.
        ce <= 1'b0;
        tester.scan(28'h0158000, vout);
        check("frozen", 32'h80EFFFE, 32'(seen_lines));
        ce <= 1'b1;
        apb(1'b1, 12'h000, 32'h0);
        $display("register test done");
        presetn <= 1'b0;
        @(posedge pclk);
        check("reset", 32'h0158000, {tdo, 3'h0, seen_lines});
        presetn <= 1'b1;
        prev = 28'h0158000;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check("enable after reset", 32'h1, rd);
        tester.scan(28'h0858010, vout);
        check("capture after reset", 32'h0158000, 32'(vout));
        check("lines after reset", 32'h0858010, 32'(seen_lines));
        $display("reset test done");
        give_verdict();
    end
endmodule
`default_nettype wire
